// *** rtl/position_setpoint_follower.sv ***
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module position_setpoint_follower #(
    parameter int unsigned TICK_CYCLES = psf_pkg::TICK_CYC
) (
    input  wire logic                    mclk,
    input  wire logic                    arst_n,
    input  wire logic                    hsel,
    input  wire logic [psf_pkg::DW-1:0]  haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [psf_pkg::DW-1:0]  hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [psf_pkg::DW-1:0]       hrdata,
    input  wire logic                    sync_pin,
    input  wire logic                    nmt_oper_pin,
    input  wire logic                    quick_stop_pin,
    input  wire logic [psf_pkg::DW-1:0]  actual_pos,
    output logic [psf_pkg::DW-1:0]       demand_pos,
    output logic [15:0]                  status_word
);
    import psf_pkg::*;

    localparam int unsigned TW = $clog2(TICK_CYCLES);

    if (TICK_CYCLES < 2) begin : g_chk
        $error("TICK_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [TW-1:0] tick_cnt_q;
    logic          tick_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] lvl_q;
    logic       sync_prev_q;
    logic       sync_edge;
    logic       oper;
    logic       qstop;

    assign pin_raw = {quick_stop_pin, nmt_oper_pin, sync_pin};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        // Level moves only when two late stages agree
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                s1_q[i]  <= 1'b0;
                s2_q[i]  <= 1'b0;
                s3_q[i]  <= 1'b0;
                lvl_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= pin_raw[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync_prev_q <= 1'b0;
        end else begin
            sync_prev_q <= lvl_q[0];
        end
    end

    assign sync_edge = lvl_q[0] & ~sync_prev_q;
    assign oper      = lvl_q[1];
    assign qstop     = lvl_q[2];

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic              wr_pend_q;
    logic [7:0]        wr_addr_q;
    logic              take;
    logic [7:0]        mode_q;
    logic [15:0]       ctrl_q;
    logic signed [31:0] ip_buf_q;
    logic [7:0]        period_q;
    logic [7:0]        tidx_q;
    logic [7:0]        bufcfg_q;
    logic signed [31:0] sw_min_q;
    logic signed [31:0] sw_max_q;
    logic signed [31:0] csp_tgt_q;
    logic signed [31:0] rg_min_q;
    logic signed [31:0] rg_max_q;
    logic [31:0]       fe_win_q;
    logic [15:0]       fe_tmo_q;
    logic [31:0]       qs_dec_q;
    logic [31:0]       hlt_dec_q;
    logic [31:0]       accel_q;
    logic signed [31:0] demand_q;
    logic [15:0]       status_q;
    logic [31:0]       rd_mux;
    logic              ip_wr;

    assign take  = hsel & htrans[1] & hready;
    assign ip_wr = wr_pend_q & (wr_addr_q == OFF_IPTGT) & (bufcfg_q == BUF_ENABLE);

    always_comb begin
        unique case (haddr[7:0])
            OFF_MODE:   rd_mux = {24'h0, mode_q};
            OFF_CTRL:   rd_mux = {16'h0, ctrl_q};
            OFF_STAT:   rd_mux = {16'h0, status_q};
            OFF_IPTGT:  rd_mux = ip_buf_q;
            OFF_PERIOD: rd_mux = {24'h0, period_q};
            OFF_TIDX:   rd_mux = {24'h0, tidx_q};
            OFF_BUFCFG: rd_mux = {24'h0, bufcfg_q};
            OFF_SWMIN:  rd_mux = sw_min_q;
            OFF_SWMAX:  rd_mux = sw_max_q;
            OFF_CSPTGT: rd_mux = csp_tgt_q;
            OFF_RGMIN:  rd_mux = rg_min_q;
            OFF_RGMAX:  rd_mux = rg_max_q;
            OFF_FEWIN:  rd_mux = fe_win_q;
            OFF_FETMO:  rd_mux = {16'h0, fe_tmo_q};
            OFF_QSDEC:  rd_mux = qs_dec_q;
            OFF_HLTDEC: rd_mux = hlt_dec_q;
            OFF_ACCEL:  rd_mux = accel_q;
            OFF_DEMAND: rd_mux = demand_q;
            OFF_ACTUAL: rd_mux = actual_pos;
            default:    rd_mux = RST_WORD;
        endcase
    end

    // Zero wait states; read data staged at the address phase
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata    <= RST_WORD;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= take & hwrite;
            if (take) begin
                wr_addr_q <= haddr[7:0];
            end
            if (take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q    <= 8'h00;
            ctrl_q    <= 16'h0000;
            ip_buf_q  <= RST_WORD;
            period_q  <= 8'h00;
            tidx_q    <= RST_TIDX;
            bufcfg_q  <= 8'h00;
            sw_min_q  <= RST_WORD;
            sw_max_q  <= RST_WORD;
            csp_tgt_q <= RST_WORD;
            rg_min_q  <= RST_WORD;
            rg_max_q  <= RST_WORD;
            fe_win_q  <= RST_WORD;
            fe_tmo_q  <= 16'h0000;
            qs_dec_q  <= RST_WORD;
            hlt_dec_q <= RST_WORD;
            accel_q   <= RST_WORD;
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                OFF_MODE:   mode_q    <= hwdata[7:0];
                OFF_CTRL:   ctrl_q    <= hwdata[15:0];
                OFF_IPTGT:  if (ip_wr) ip_buf_q <= hwdata;
                OFF_PERIOD: period_q  <= hwdata[7:0];
                OFF_TIDX:   tidx_q    <= hwdata[7:0];
                OFF_BUFCFG: bufcfg_q  <= hwdata[7:0];
                OFF_SWMIN:  sw_min_q  <= hwdata;
                OFF_SWMAX:  sw_max_q  <= hwdata;
                OFF_CSPTGT: csp_tgt_q <= hwdata;
                OFF_RGMIN:  rg_min_q  <= hwdata;
                OFF_RGMAX:  rg_max_q  <= hwdata;
                OFF_FEWIN:  fe_win_q  <= hwdata;
                OFF_FETMO:  fe_tmo_q  <= hwdata[15:0];
                OFF_QSDEC:  qs_dec_q  <= hwdata;
                OFF_HLTDEC: hlt_dec_q <= hwdata;
                OFF_ACCEL:  accel_q   <= hwdata;
                default:    ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // SYNC tracking
    // ------------------------------------------------------------
    logic       synced_q;
    logic [9:0] gap_q;
    logic [9:0] gap_lim;

    assign gap_lim = 10'(SYNC_LOSS_MULT) * {2'b00, period_q};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            synced_q <= 1'b0;
            gap_q    <= 10'h000;
        end else if (!oper || period_q == 8'h00) begin
            synced_q <= 1'b0;
            gap_q    <= 10'h000;
        end else if (sync_edge) begin
            synced_q <= 1'b1;
            gap_q    <= 10'h000;
        end else if (tick_q) begin
            if (gap_q >= gap_lim) begin
                synced_q <= 1'b0;
            end else begin
                gap_q <= gap_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Motion
    // ------------------------------------------------------------
    logic               mode_ip;
    logic               mode_csp;
    logic               base_ok;
    logic               ip_active;
    logic               csp_follow;
    logic               halt;
    logic               ip_buf_vld_q;
    logic               seg_load;
    logic signed [31:0] ip_tgt_q;
    logic [7:0]         ticks_q;
    logic [31:0]        spd_q;
    logic               dir_q;
    logic signed [32:0] remain;
    logic signed [32:0] want;
    logic [32:0]        mag;
    logic [32:0]        lim;
    logic [31:0]        brake_dec;
    logic [31:0]        spd_brk;
    logic [31:0]        step_mag;

    assign mode_ip    = (mode_q == MODE_IP);
    assign mode_csp   = (mode_q == MODE_CSP);
    assign base_ok    = (tidx_q == TIDX_MS);
    assign ip_active  = mode_ip & ctrl_q[CW_START] & synced_q & base_ok;
    assign csp_follow = mode_csp & synced_q & base_ok & ~qstop;
    assign halt       = ctrl_q[CW_HALT];
    // segment taken from buffer on SYNC
    assign seg_load   = sync_edge & ip_active & ip_buf_vld_q;

    function automatic logic signed [31:0] wrap(input logic signed [31:0] p);
        logic signed [32:0] t;
        logic signed [32:0] span;
        t    = {p[31], p};
        span = {rg_max_q[31], rg_max_q} - {rg_min_q[31], rg_min_q} + 33'sd1;
        if (rg_max_q > rg_min_q) begin
            if (p > rg_max_q) begin
                t = t - span;
            end else if (p < rg_min_q) begin
                t = t + span;
            end
        end
        wrap = t[31:0];
    endfunction : wrap

    // Set from a write wins over consumption in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ip_buf_vld_q <= 1'b0;
        end else begin
            if (seg_load || !mode_ip) begin
                ip_buf_vld_q <= 1'b0;
            end
            if (ip_wr) begin
                ip_buf_vld_q <= 1'b1;
            end
        end
    end

    always_comb begin
        remain = {ip_tgt_q[31], ip_tgt_q} - {demand_q[31], demand_q};
        // equal share of what is left
        if (ticks_q != 8'h00) begin
            want = remain / $signed({25'h0, ticks_q});
        end else begin
            want = 33'sd0;
        end
        mag = want[32] ? 33'(-want) : 33'(want);
        lim = {1'b0, spd_q} + {1'b0, accel_q};
        if (mag > lim && ticks_q > 8'h01) begin
            step_mag = lim[32] ? 32'hFFFF_FFFF : lim[31:0];
        end else begin
            step_mag = mag[31:0];
        end
        brake_dec = qstop ? qs_dec_q : hlt_dec_q;
        spd_brk   = (spd_q > brake_dec) ? spd_q - brake_dec : 32'h0000_0000;
    end

    // Division is combinational: long path traded for exact arrival
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            demand_q <= RST_WORD;
            ip_tgt_q <= RST_WORD;
            ticks_q  <= 8'h00;
            spd_q    <= RST_WORD;
            dir_q    <= 1'b0;
        end else if (seg_load) begin
            ip_tgt_q <= wrap(ip_buf_q);
            ticks_q  <= period_q;
        end else if (mode_csp && csp_follow && sync_edge) begin
            demand_q <= wrap(csp_tgt_q);
            spd_q    <= RST_WORD;
        end else if (tick_q) begin
            if ((mode_ip || mode_csp) && (qstop || (mode_ip && halt))) begin
                spd_q    <= spd_brk;
                demand_q <= dir_q ? demand_q - spd_brk : demand_q + spd_brk;
            end else if (ip_active && ticks_q != 8'h00) begin
                // linear motion toward the one target
                spd_q    <= step_mag;
                dir_q    <= want[32];
                demand_q <= want[32] ? demand_q - step_mag : demand_q + step_mag;
                ticks_q  <= ticks_q - 1'b1;
            end else begin
                spd_q <= RST_WORD;
            end
        end
    end

    // ------------------------------------------------------------
    // Following error
    // ------------------------------------------------------------
    logic signed [32:0] perr;
    logic [32:0]        perr_mag;
    logic               outside;
    logic [15:0]        fe_cnt_q;
    logic               ferr_q;

    assign perr     = {actual_pos[31], actual_pos} - {demand_q[31], demand_q};
    assign perr_mag = perr[32] ? 33'(-perr) : 33'(perr);
    assign outside  = perr_mag > {1'b0, fe_win_q};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fe_cnt_q <= 16'h0000;
            ferr_q   <= 1'b0;
        end else if (!outside) begin
            fe_cnt_q <= 16'h0000;
            ferr_q   <= 1'b0;
        end else if (tick_q) begin
            if (fe_cnt_q >= fe_tmo_q) begin
                ferr_q <= 1'b1;
            end else begin
                fe_cnt_q <= fe_cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    logic limit_hit;
    logic reached;

    // limits enabled only when max above min
    assign limit_hit = (sw_max_q > sw_min_q) && (demand_q < sw_min_q || demand_q > sw_max_q);
    assign reached   = halt ? (spd_q == RST_WORD)
                            : (ticks_q == 8'h00 && demand_q == ip_tgt_q);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= 16'h0000;
        end else begin
            status_q <= 16'h0000;
            status_q[SW_SYNC]    <= mode_csp & synced_q;
            status_q[SW_REACHED] <= mode_ip & reached;
            status_q[SW_LIMIT]   <= (mode_ip | mode_csp) & limit_hit;
            status_q[SW_ACTIVE]  <= mode_ip ? ip_active : csp_follow;
            status_q[SW_FERR]    <= ferr_q;
        end
    end

    assign status_word = status_q;
    assign demand_pos  = demand_q;

endmodule : position_setpoint_follower

// *** rtl/psf_pkg.sv ***
package psf_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned TICK_MS        = 1;
    localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned SYNC_LOSS_MULT = 2;
    localparam int unsigned DW             = 32;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_MODE   = 8'h00;
    localparam logic [7:0] OFF_CTRL   = 8'h04;
    localparam logic [7:0] OFF_STAT   = 8'h08;
    localparam logic [7:0] OFF_IPTGT  = 8'h0C;
    localparam logic [7:0] OFF_PERIOD = 8'h10;
    localparam logic [7:0] OFF_TIDX   = 8'h14;
    localparam logic [7:0] OFF_BUFCFG = 8'h18;
    localparam logic [7:0] OFF_SWMIN  = 8'h1C;
    localparam logic [7:0] OFF_SWMAX  = 8'h20;
    localparam logic [7:0] OFF_CSPTGT = 8'h24;
    localparam logic [7:0] OFF_RGMIN  = 8'h28;
    localparam logic [7:0] OFF_RGMAX  = 8'h2C;
    localparam logic [7:0] OFF_FEWIN  = 8'h30;
    localparam logic [7:0] OFF_FETMO  = 8'h34;
    localparam logic [7:0] OFF_QSDEC  = 8'h38;
    localparam logic [7:0] OFF_HLTDEC = 8'h3C;
    localparam logic [7:0] OFF_ACCEL  = 8'h40;
    localparam logic [7:0] OFF_DEMAND = 8'h44;
    localparam logic [7:0] OFF_ACTUAL = 8'h48;
    // ------------------------------------------------------------
    // Codes, fields and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_IP       = 8'h07;
    localparam logic [7:0] MODE_CSP      = 8'h08;
    localparam logic [7:0] TIDX_MS       = 8'hFD;
    localparam logic [7:0] BUF_ENABLE    = 8'h01;
    localparam int unsigned CW_START     = 4;
    localparam int unsigned CW_HALT      = 8;
    localparam int unsigned SW_SYNC      = 8;
    localparam int unsigned SW_REACHED   = 10;
    localparam int unsigned SW_LIMIT     = 11;
    localparam int unsigned SW_ACTIVE    = 12;
    localparam int unsigned SW_FERR      = 13;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [7:0]  RST_TIDX     = 8'hFD;
endpackage : psf_pkg

// *** verification/psf_asserts.sv ***
`timescale 1ns/10ps
module psf_asserts
    import psf_pkg::*;
(
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        nmt_oper_pin,
    input wire logic [31:0] actual_pos,
    input wire logic [31:0] demand_pos,
    input wire logic [15:0] status_word
);
    logic [3:0] nmt_q;
    logic       same;
    assign same = actual_pos == demand_pos;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Saturates so a long online spell never wraps
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) nmt_q <= 4'h0;
        else if (!nmt_oper_pin) nmt_q <= 4'h0;
        else if (nmt_q != 4'hF) nmt_q <= nmt_q + 4'h1;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    ready_high_a:
        assert property (hreadyout == 1'b1 && hresp == 1'b0) else $error("bus stalled");
    rdata_hold_a:
        assert property (!(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata))
        else $error("read data moved");
    spare_bits_a:
        assert property ((status_word & 16'hC2FF) == 16'h0000) else $error("spare bit set");
    mode_bits_a:
        assert property (!(status_word[SW_SYNC] && status_word[SW_REACHED]))
        else $error("sync and reached together");
    sync_lost_a:
        assert property (!nmt_oper_pin [*7] |-> !status_word[SW_SYNC])
        else $error("sync kept offline");
    sync_nmt_a:
        assert property ($rose(status_word[SW_SYNC]) |-> nmt_q >= 4'h3)
        else $error("sync before operational");
    ferr_cause_a:
        assert property ($rose(status_word[SW_FERR]) |-> !$past(same) || !$past(same, 2))
        else $error("following error without offset");
    ferr_clear_a:
        assert property (same [*3] |-> !status_word[SW_FERR])
        else $error("following error kept");
endmodule : psf_asserts

bind position_setpoint_follower psf_asserts chk_i (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .nmt_oper_pin(nmt_oper_pin), .actual_pos(actual_pos), .demand_pos(demand_pos),
    .status_word(status_word)
);

// *** verification/motion_master.sv ***
`timescale 1ns/10ps
module motion_master #(
    parameter int unsigned SYNC_CYC = 40
) (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic online,
    output logic      sync_pin,
    output logic      nmt_oper_pin
);
    int unsigned cnt_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q        <= 0;
            sync_pin     <= 1'b0;
            nmt_oper_pin <= 1'b0;
        end else begin
            cnt_q        <= (!online || cnt_q == SYNC_CYC - 1) ? 0 : cnt_q + 1;
            sync_pin     <= online && cnt_q < 4;
            nmt_oper_pin <= online;
        end
    end
endmodule : motion_master

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import psf_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic        mclk       = 1'b0;
    logic        arst_n     = 1'b0;
    logic [31:0] haddr      = 32'h0;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'b0;
    logic [31:0] hwdata     = 32'h0;
    logic [31:0] actual_pos = 32'h0;
    logic        online     = 1'b0;
    logic        quick_stop = 1'b0;
    wire         hready;
    wire         sync_pin;
    wire         nmt_oper_pin;
    wire  [31:0] hrdata;
    wire  [31:0] demand_pos;
    wire  [15:0] status_word;
    int          fails       = 0;
    int          checks_done = 0;

    always #20 mclk = ~mclk;

    position_setpoint_follower #(.TICK_CYCLES(20)) uut (
        .mclk(mclk), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(), .hrdata(hrdata), .sync_pin(sync_pin),
        .nmt_oper_pin(nmt_oper_pin), .quick_stop_pin(quick_stop), .actual_pos(actual_pos),
        .demand_pos(demand_pos), .status_word(status_word));
    motion_master #(.SYNC_CYC(40)) master (
        .mclk(mclk), .arst_n(arst_n), .online(online), .sync_pin(sync_pin),
        .nmt_oper_pin(nmt_oper_pin));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic io(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge mclk);
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : io
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        io(1'b1, a, d, q);
    endtask : wr
    // Polls up to n reads so the bench assumes no exact motion latency
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] m,
                              input logic [31:0] e, input int n);
        logic [31:0] q;
        io(1'b0, a, 32'h0, q);
        for (int i = 1; i < n && (q & m) !== e; i++) io(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask : expect_reg
    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (40000) @(posedge mclk);
        fails++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        expect_reg(OFF_TIDX, ALL, 32'hFD, 1);
        wr(OFF_STAT, ALL);
        expect_reg(OFF_STAT, ALL, 32'h0, 1);
        expect_reg(8'h4C, ALL, 32'h0, 1);
        $display("test reset done");
        wr(OFF_FEWIN, 32'h1F4);
        wr(OFF_PERIOD, 32'h2);
        wr(OFF_TIDX, 32'h0);
        wr(OFF_MODE, {24'h0, MODE_CSP});
        wr(OFF_CSPTGT, 32'h64);
        online <= 1'b1;
        repeat (200) @(posedge mclk);
        expect_reg(OFF_DEMAND, ALL, 32'h0, 1);
        wr(OFF_TIDX, {24'h0, TIDX_MS});
        expect_reg(OFF_DEMAND, ALL, 32'h64, 300);
        expect_reg(OFF_STAT, 32'h1100, 32'h1100, 300);
        repeat (3) wr(OFF_CSPTGT, 32'h96);
        repeat (100) @(posedge mclk);
        expect_reg(OFF_DEMAND, ALL, 32'h96, 1);
        wr(OFF_SWMAX, 32'h78);
        expect_reg(OFF_STAT, 32'h800, 32'h800, 300);
        wr(OFF_CSPTGT, 32'h6E);
        expect_reg(OFF_STAT, 32'h800, 32'h0, 300);
        $display("test cyclic done");
        wr(OFF_FETMO, 32'h2);
        wr(OFF_FEWIN, 32'hA);
        expect_reg(OFF_STAT, 32'h2000, 32'h0, 1);
        expect_reg(OFF_STAT, 32'h2000, 32'h2000, 300);
        actual_pos <= 32'h69;
        expect_reg(OFF_STAT, 32'h2000, 32'h0, 300);
        online <= 1'b0;
        expect_reg(OFF_STAT, 32'h100, 32'h0, 300);
        online <= 1'b1;
        expect_reg(OFF_STAT, 32'h100, 32'h100, 300);
        $display("test sync and error done");
        wr(OFF_ACCEL, 32'h1000);
        wr(OFF_HLTDEC, 32'h1000);
        wr(OFF_MODE, {24'h0, MODE_IP});
        expect_reg(OFF_MODE, ALL, 32'h7, 1);
        wr(OFF_BUFCFG, 32'h1);
        wr(OFF_IPTGT, 32'hAA);
        wr(OFF_BUFCFG, 32'h0);
        wr(OFF_IPTGT, 32'h1F4);
        repeat (200) @(posedge mclk);
        expect_reg(OFF_DEMAND, ALL, 32'h6E, 1);
        wr(OFF_CTRL, 32'h10);
        expect_reg(OFF_DEMAND, ALL, 32'h8C, 300);
        expect_reg(OFF_DEMAND, ALL, 32'hAA, 300);
        expect_reg(OFF_STAT, 32'h1400, 32'h1400, 300);
        wr(OFF_BUFCFG, 32'h1);
        wr(OFF_IPTGT, 32'h12C);
        wr(OFF_CTRL, 32'h110);
        expect_reg(OFF_STAT, 32'h400, 32'h400, 300);
        wr(OFF_CTRL, 32'h0);
        expect_reg(OFF_STAT, 32'h1000, 32'h0, 300);
        $display("test interpolation done");
        wr(OFF_MODE, {24'h0, MODE_CSP});
        wr(OFF_RGMAX, 32'hFF);
        wr(OFF_CSPTGT, 32'h150);
        expect_reg(OFF_DEMAND, ALL, 32'h50, 300);
        quick_stop <= 1'b1;
        // Follow must be off before the new target lands
        expect_reg(OFF_STAT, 32'h1000, 32'h0, 300);
        wr(OFF_CSPTGT, 32'h40);
        repeat (100) @(posedge mclk);
        expect_reg(OFF_DEMAND, ALL, 32'h50, 1);
        quick_stop <= 1'b0;
        expect_reg(OFF_DEMAND, ALL, 32'h40, 300);
        $display("test range and quick stop done");
        final_report();
    end
endmodule : tb_top
